// ### logic/irq_wdt_pkg.sv
package irq_wdt_pkg;

  // ----------------------------------------------------------------
  // Vectors
  // ----------------------------------------------------------------
  localparam logic [9:0] VEC_TRAP = 10'h001;
  localparam logic [9:0] VEC_HW   = 10'h008;

  // ----------------------------------------------------------------
  // Flag and enable bit positions
  // ----------------------------------------------------------------
  localparam int BIT_T0  = 0;
  localparam int BIT_PB  = 1;
  localparam int BIT_EXT = 2;
  localparam int BIT_T1  = 3;
  localparam int BIT_WDT = 6;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] FLAG_RST    = 8'h00;
  localparam logic [7:0] ENABLE_RST  = 8'h00;
  localparam logic       GIE_RST     = 1'b0;
  localparam logic       TIMEOUT_RST = 1'b1;
  localparam logic       PDOWN_RST   = 1'b1;
  localparam logic [7:0] PRESC_RST   = 8'h00;
  localparam logic [19:0] WDT_CNT_RST = 20'h00000;

  // ----------------------------------------------------------------
  // Timer wrap detection values and port B pin 0 mask
  // ----------------------------------------------------------------
  localparam logic [7:0] CNT_TOP = 8'hff;
  localparam logic [7:0] CNT_BOT = 8'h00;
  localparam logic [7:0] PIN0_MASK = 8'h01;

  // ----------------------------------------------------------------
  // Watchdog base periods in microseconds, oscillator rate in kHz
  // ----------------------------------------------------------------
  localparam int WDT_P0_US = 3500;
  localparam int WDT_P1_US = 15000;
  localparam int WDT_P2_US = 60000;
  localparam int WDT_P3_US = 250000;
  localparam int WDT_OSC_KHZ_DEF = 32;

  // Base period select codes
  typedef enum logic [1:0] {
    WDT_SEL_3P5MS = 2'b00,
    WDT_SEL_15MS  = 2'b01,
    WDT_SEL_60MS  = 2'b10,
    WDT_SEL_250MS = 2'b11
  } wdt_period_t;

endpackage

// ### logic/pin_sync_edge.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync_edge (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic [8:0] pins_i,
  output logic      [8:0] level_o,
  output logic      [8:0] rise_o,
  output logic      [8:0] fall_o
);
  logic [8:0] meta_ff;
  logic [8:0] sync_ff;
  logic [8:0] prev_ff;

  // ----------------------------------------------------------------
  // Two-stage synchroniser, then a history stage
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      meta_ff <= 9'h000;
      sync_ff <= 9'h000;
      prev_ff <= 9'h000;
    end else begin
      meta_ff <= pins_i;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // Edge pulses from the synchronised level only
  assign level_o = sync_ff;
  assign rise_o  = sync_ff & ~prev_ff;
  assign fall_o  = ~sync_ff & prev_ff;
endmodule
`default_nettype wire

// ### logic/watchdog_core.sv
`timescale 1ns/10ps
`default_nettype none
module watchdog_core
  import irq_wdt_pkg::*;
#(
  parameter int WDT_OSC_KHZ = WDT_OSC_KHZ_DEF
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       osc_tick_i,
  input  wire logic       run_i,
  input  wire logic       clear_i,
  input  wire logic       presc_assigned_i,
  input  wire logic [2:0] ratio_sel_i,
  input  wire logic       irq_mode_i,
  input  wire logic [1:0] period_sel_i,
  output logic            expire_o
);
  localparam logic [19:0] LIM0 = 20'(WDT_P0_US * WDT_OSC_KHZ / 1000);
  localparam logic [19:0] LIM1 = 20'(WDT_P1_US * WDT_OSC_KHZ / 1000);
  localparam logic [19:0] LIM2 = 20'(WDT_P2_US * WDT_OSC_KHZ / 1000);
  localparam logic [19:0] LIM3 = 20'(WDT_P3_US * WDT_OSC_KHZ / 1000);

  logic [7:0]  presc_ff;
  logic [19:0] cnt_ff;
  logic [19:0] limit;
  logic [8:0]  div_mask;
  logic        step;

  // Base period from the two select bits
  always_comb begin
    case (wdt_period_t'(period_sel_i))
      WDT_SEL_3P5MS: limit = LIM0;
      WDT_SEL_15MS:  limit = LIM1;
      WDT_SEL_60MS:  limit = LIM2;
      default:       limit = LIM3;
    endcase
  end

  // Prescaler ratio: 1..128 in reset mode, 2..256 in interrupt mode
  assign div_mask = irq_mode_i ? ((9'h002 << ratio_sel_i) - 9'h001)
                               : ((9'h001 << ratio_sel_i) - 9'h001);
  assign step = osc_tick_i & (~presc_assigned_i | ({1'b0, presc_ff} == div_mask));

  // ----------------------------------------------------------------
  // Prescaler and counter, stepped by the free-running oscillator
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      presc_ff <= PRESC_RST;
    end else if (clear_i && presc_assigned_i) begin
      presc_ff <= PRESC_RST;
    end else if (run_i && osc_tick_i && presc_assigned_i) begin
      presc_ff <= (step) ? PRESC_RST : presc_ff + 8'h01;
    end
  end

  // Counter runs whatever the power mode, only gated by enables
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt_ff   <= WDT_CNT_RST;
      expire_o <= 1'b0;
    end else begin
      expire_o <= 1'b0;
      if (clear_i) begin
        cnt_ff <= WDT_CNT_RST;
      end else if (run_i && step) begin
        if (cnt_ff >= limit - 20'h00001) begin
          cnt_ff   <= WDT_CNT_RST;
          expire_o <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 20'h00001;
        end
      end
    end
  end

  // Checks
  chk_clear_zeroes: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    clear_i && presc_assigned_i |=> cnt_ff == WDT_CNT_RST && presc_ff == PRESC_RST)
    else $error("watchdog clear did not zero counter and prescaler");
  chk_stop_holds: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !run_i && !clear_i |=> !expire_o && cnt_ff == $past(cnt_ff))
    else $error("watchdog counted while stopped");
endmodule
`default_nettype wire

// ### logic/interrupt_and_watchdog_unit.sv
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Watchdog expiry resets or interrupts per setting, and clears the timeout flag.
// - Run enable starts or stops watchdog counting when configuration enables it.
// - Base watchdog period is 3.5, 15, 60 or 250 ms by two settings.
// - Prescaler to watchdog divides 1..128 in reset mode, 2..256 in interrupt mode.
// - Watchdog clear with prescaler assigned zeroes both and sets timeout flag.
// - Interrupt mode expiry sets flag bit 6; request needs enable 6 and global.
// - Watchdog counts from its own oscillator, also during standby and halt.
// - Five hardware sources plus one software trap instruction.
// - Hardware interrupts only with global enable; enable and disable instructions.
// - Trap vectors to 0x001 regardless, clearing global enable.
// - Return from service sets global enable and resumes.
// - Each event sets its flag; it stays until software writes 0.
// - A flag reads as set only when its enable bit is 1.
// - Enabled flag with global enable vectors to 0x008 and clears global enable.
// - Return from service clears the in-service state.
// - Timer 0 wrap sets timer 0 flag, serviced with its enable.
// - Timer 1 underflow sets timer 1 flag, serviced with its enable.
// - Input port B pins with change enable set the change flag on any level change.
// - External select at 1 removes pin 0 from change detection.
// - External select at 1: chosen pin 0 edge sets external flag.
// - Halt entry clears power-down flag, sets timeout flag, clears watchdog.
// - Wake-up with global enable vectors to 0x008, else continues.
module interrupt_and_watchdog_unit
  import irq_wdt_pkg::*;
#(
  parameter int WDT_OSC_KHZ = irq_wdt_pkg::WDT_OSC_KHZ_DEF
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       cfg_wdt_enable_i,
  input  wire logic       cfg_wdt_irq_mode_i,
  input  wire logic [1:0] cfg_wdt_period_sel_i,
  input  wire logic       watchdog_run_enable_i,
  input  wire logic       prescaler_to_watchdog_select_i,
  input  wire logic [2:0] prescaler_ratio_select_i,
  input  wire logic       wdt_osc_i,
  input  wire logic [7:0] timer0_count_i,
  input  wire logic [7:0] timer1_count_i,
  input  wire logic [7:0] portb_pin_i,
  input  wire logic [7:0] portb_dir_input_i,
  input  wire logic [7:0] portb_pin_change_enable_i,
  input  wire logic       external_irq_select_i,
  input  wire logic       external_edge_select_i,
  input  wire logic       flag_wr_i,
  input  wire logic [7:0] flag_wdata_i,
  input  wire logic       enable_wr_i,
  input  wire logic [7:0] enable_wdata_i,
  input  wire logic       enable_irq_instruction_i,
  input  wire logic       disable_irq_instruction_i,
  input  wire logic       return_from_isr_instruction_i,
  input  wire logic       sw_trap_instruction_i,
  input  wire logic       watchdog_clear_instruction_i,
  input  wire logic       halt_entry_i,
  input  wire logic       standby_entry_i,
  output logic      [7:0] interrupt_flag_reg_o,
  output logic      [7:0] interrupt_enable_reg_o,
  output logic            global_irq_enable_o,
  output logic            vector_load_o,
  output logic      [9:0] vector_addr_o,
  output logic            isr_active_o,
  output logic            timeout_status_flag_o,
  output logic            power_down_flag_o,
  output logic            watchdog_reset_o,
  output logic            wake_o
);
  import irq_wdt_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] flags_ff;
  logic [7:0] nxt_flags;
  logic [7:0] nxt_enable;
  logic [7:0] set_vec;
  logic [7:0] t0_prev_ff;
  logic [7:0] t1_prev_ff;
  logic [8:0] pin_level;
  logic [8:0] pin_rise;
  logic [8:0] pin_fall;
  logic [7:0] change_mask;
  logic       t0_wrap;
  logic       t1_wrap;
  logic       pb_change;
  logic       ext_edge;
  logic       wdt_expire;
  logic       wdt_run;
  logic       wdt_clear;
  logic       hw_take;
  logic       sleep_ff;
  logic       any_enabled;

  // ----------------------------------------------------------------
  // Pin synchronisers: port B and watchdog oscillator
  // ----------------------------------------------------------------
  pin_sync_edge u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .pins_i    ({wdt_osc_i, portb_pin_i}),
    .level_o   (pin_level),
    .rise_o    (pin_rise),
    .fall_o    (pin_fall)
  );

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  assign wdt_run   = cfg_wdt_enable_i & watchdog_run_enable_i;
  assign wdt_clear = watchdog_clear_instruction_i | halt_entry_i;

  watchdog_core #(
    .WDT_OSC_KHZ (WDT_OSC_KHZ)
  ) u_wdt (
    .ref_clk_i        (ref_clk_i),
    .rst_i            (rst_i),
    .osc_tick_i       (pin_rise[8]),
    .run_i            (wdt_run),
    .clear_i          (wdt_clear),
    .presc_assigned_i (prescaler_to_watchdog_select_i),
    .ratio_sel_i      (prescaler_ratio_select_i),
    .irq_mode_i       (cfg_wdt_irq_mode_i),
    .period_sel_i     (cfg_wdt_period_sel_i),
    .expire_o         (wdt_expire)
  );

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  // Timer count history for wrap detection
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      t0_prev_ff <= CNT_BOT;
      t1_prev_ff <= CNT_BOT;
    end else begin
      t0_prev_ff <= timer0_count_i;
      t1_prev_ff <= timer1_count_i;
    end
  end

  assign t0_wrap = (t0_prev_ff == CNT_TOP) && (timer0_count_i == CNT_BOT);
  assign t1_wrap = (t1_prev_ff != CNT_BOT) && (timer1_count_i == CNT_BOT);

  // Pin 0 leaves change detection while external select is set
  assign change_mask = portb_dir_input_i & portb_pin_change_enable_i
                     & ~(external_irq_select_i ? PIN0_MASK : CNT_BOT);
  assign pb_change   = |((pin_rise[7:0] | pin_fall[7:0]) & change_mask);
  assign ext_edge    = external_irq_select_i
                     & (external_edge_select_i ? pin_rise[0] : pin_fall[0]);

  // Sticky set vector, one bit per source
  always_comb begin
    set_vec          = 8'h00;
    set_vec[BIT_T0]  = t0_wrap;
    set_vec[BIT_T1]  = t1_wrap;
    set_vec[BIT_PB]  = pb_change;
    set_vec[BIT_EXT] = ext_edge;
    set_vec[BIT_WDT] = wdt_expire & cfg_wdt_irq_mode_i;
  end

  // ----------------------------------------------------------------
  // Flag and enable registers
  // ----------------------------------------------------------------
  // Writing 0 clears, writing 1 keeps; a same-cycle event wins
  assign nxt_flags  = ((flag_wr_i ? (flags_ff & flag_wdata_i) : flags_ff)) | set_vec;
  assign nxt_enable = enable_wr_i ? enable_wdata_i : interrupt_enable_reg_o;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      flags_ff <= FLAG_RST;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // Enable register and masked read view
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      interrupt_enable_reg_o <= ENABLE_RST;
      interrupt_flag_reg_o   <= FLAG_RST;
    end else begin
      interrupt_enable_reg_o <= nxt_enable;
      interrupt_flag_reg_o   <= nxt_flags & nxt_enable;
    end
  end

  // ----------------------------------------------------------------
  // Global enable and vectoring
  // ----------------------------------------------------------------
  // Any enabled flag requests the one shared vector
  assign any_enabled = |(flags_ff & interrupt_enable_reg_o);
  assign hw_take     = global_irq_enable_o & any_enabled
                     & ~sw_trap_instruction_i;

  // Global enable: automatic clear beats disable, disable beats set
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      global_irq_enable_o <= GIE_RST;
    end else if (sw_trap_instruction_i || hw_take) begin
      global_irq_enable_o <= 1'b0;
    end else if (disable_irq_instruction_i) begin
      global_irq_enable_o <= 1'b0;
    end else if (enable_irq_instruction_i || return_from_isr_instruction_i) begin
      global_irq_enable_o <= 1'b1;
    end
  end

  // Vector request to the sequencer, trap first
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      vector_load_o <= 1'b0;
      vector_addr_o <= VEC_HW;
    end else begin
      vector_load_o <= sw_trap_instruction_i | hw_take;
      if (sw_trap_instruction_i) begin
        vector_addr_o <= VEC_TRAP;
      end else if (hw_take) begin
        vector_addr_o <= VEC_HW;
      end
    end
  end

  // In-service state, left by return from service
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      isr_active_o <= 1'b0;
    end else if (sw_trap_instruction_i || hw_take) begin
      isr_active_o <= 1'b1;
    end else if (return_from_isr_instruction_i) begin
      isr_active_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Power modes and status flags
  // ----------------------------------------------------------------
  // Sleep tracking and wake pulse on any enabled flag
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sleep_ff <= 1'b0;
      wake_o   <= 1'b0;
    end else begin
      wake_o <= sleep_ff & any_enabled;
      if (sleep_ff && any_enabled) begin
        sleep_ff <= 1'b0;
      end else if (halt_entry_i || standby_entry_i) begin
        sleep_ff <= 1'b1;
      end
    end
  end

  // Timeout flag: expiry clears, halt or watchdog clear with prescaler assigned sets
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      timeout_status_flag_o <= TIMEOUT_RST;
    end else if (wdt_expire) begin
      timeout_status_flag_o <= 1'b0;
    end else if (halt_entry_i ||
                 (watchdog_clear_instruction_i && prescaler_to_watchdog_select_i)) begin
      timeout_status_flag_o <= 1'b1;
    end
  end

  // Power-down flag and watchdog reset request
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      power_down_flag_o <= PDOWN_RST;
      watchdog_reset_o  <= 1'b0;
    end else begin
      watchdog_reset_o <= wdt_expire & ~cfg_wdt_irq_mode_i;
      if (halt_entry_i) begin
        power_down_flag_o <= 1'b0;
      end else if (watchdog_clear_instruction_i) begin
        power_down_flag_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_trap_vector: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    sw_trap_instruction_i |=> vector_load_o && vector_addr_o == VEC_TRAP
                              && !global_irq_enable_o && isr_active_o)
    else $error("trap did not vector to 0x001");
  chk_hw_vector: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    global_irq_enable_o && any_enabled && !sw_trap_instruction_i
    |=> vector_load_o && vector_addr_o == VEC_HW && !global_irq_enable_o)
    else $error("enabled flag did not vector to 0x008");
  chk_no_gie_no_take: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !global_irq_enable_o && !sw_trap_instruction_i |=> !vector_load_o)
    else $error("vector taken without global enable");
  chk_return_sets: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    return_from_isr_instruction_i && !sw_trap_instruction_i && !hw_take
    && !disable_irq_instruction_i |=> global_irq_enable_o && !isr_active_o)
    else $error("return did not restore global enable");
  chk_flag_sticky: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    flags_ff[BIT_T0] && !flag_wr_i |=> flags_ff[BIT_T0])
    else $error("timer 0 flag dropped without a write");
  chk_set_wins: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    t1_wrap && flag_wr_i && !flag_wdata_i[BIT_T1] |=> flags_ff[BIT_T1])
    else $error("event lost against a clearing write");
  chk_read_masked: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ##1 interrupt_flag_reg_o == (flags_ff & interrupt_enable_reg_o))
    else $error("flag view not gated by enable");
  chk_wdt_irq_flag: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    wdt_expire && cfg_wdt_irq_mode_i |=> flags_ff[BIT_WDT] && !timeout_status_flag_o
                                         && !watchdog_reset_o)
    else $error("interrupt-mode expiry did not set flag 6");
  chk_wdt_reset: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    wdt_expire && !cfg_wdt_irq_mode_i |=> watchdog_reset_o && !timeout_status_flag_o
                                          && (!flags_ff[BIT_WDT] || $past(flags_ff[BIT_WDT])))
    else $error("reset-mode expiry did not request reset");
  chk_halt_flags: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    halt_entry_i && !wdt_expire |=> !power_down_flag_o && timeout_status_flag_o)
    else $error("halt entry flags wrong");
  chk_pin0_masked: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    external_irq_select_i |-> !change_mask[0])
    else $error("pin 0 still in change detection");
  chk_wake_pulse: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    sleep_ff && any_enabled |=> wake_o ##1 !wake_o)
    else $error("wake pulse missing or too long");
endmodule
`default_nettype wire

// ### sim/seq_model.sv
`timescale 1ns/10ps
`default_nettype none
module seq_model (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       vec_load_i,
  input  wire logic [9:0] vec_addr_i,
  output logic      [9:0] pc_o,
  output logic      [7:0] fetches_o
);
  // Fetch redirect on each vector pulse, with a redirect count
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pc_o      <= 10'h000;
      fetches_o <= 8'h00;
    end else if (vec_load_i) begin
      pc_o      <= vec_addr_i;
      fetches_o <= fetches_o + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ### sim/interrupt_and_watchdog_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none
module interrupt_and_watchdog_unit_tb;
  import irq_wdt_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i, cfg_wdt_enable_i, cfg_wdt_irq_mode_i, watchdog_run_enable_i, wdt_osc_i;
  logic prescaler_to_watchdog_select_i, external_irq_select_i, external_edge_select_i;
  logic flag_wr_i, enable_wr_i, enable_irq_instruction_i, disable_irq_instruction_i;
  logic return_from_isr_instruction_i, sw_trap_instruction_i, watchdog_clear_instruction_i;
  logic halt_entry_i, standby_entry_i, global_irq_enable_o, vector_load_o, isr_active_o;
  logic timeout_status_flag_o, power_down_flag_o, watchdog_reset_o, wake_o;
  logic [1:0] cfg_wdt_period_sel_i;
  logic [2:0] prescaler_ratio_select_i;
  logic [7:0] timer0_count_i, timer1_count_i, portb_pin_i, portb_dir_input_i, fetches;
  logic [7:0] portb_pin_change_enable_i, flag_wdata_i, enable_wdata_i;
  logic [7:0] interrupt_flag_reg_o, interrupt_enable_reg_o;
  logic [8:0] strb;
  logic [9:0] vector_addr_o, pc, watch;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;

  // Sequencer strobes and observed outputs
  assign {enable_wr_i, standby_entry_i, halt_entry_i, watchdog_clear_instruction_i,
          sw_trap_instruction_i, return_from_isr_instruction_i, disable_irq_instruction_i,
          enable_irq_instruction_i, flag_wr_i} = strb;
  assign watch = {watchdog_reset_o, vector_load_o, interrupt_flag_reg_o};

  interrupt_and_watchdog_unit #(.WDT_OSC_KHZ(1)) i_interrupt_and_watchdog_unit (.*);
  seq_model i_seq_model (.ref_clk_i, .rst_i, .vec_load_i(vector_load_o),
                         .vec_addr_i(vector_addr_o), .pc_o(pc), .fetches_o(fetches));

  always #10 ref_clk_i = ~ref_clk_i;

  // Watchdog oscillator of 8 cycles, and the run ceiling
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    wdt_osc_i <= cyc[2];
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle strobe with write data for both registers
  task automatic strobe(input logic [8:0] m, input logic [7:0] d);
    @(posedge ref_clk_i);
    strb <= m;
    flag_wdata_i <= d;
    enable_wdata_i <= d;
    @(posedge ref_clk_i);
    strb <= 9'h000;
    #1;
  endtask

  task automatic wait_hi(input int b, input int lim, output int n);
    n = 0;
    while (watch[b] !== 1'b1 && n < lim) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    int n;
    {strb, flag_wdata_i, enable_wdata_i, portb_pin_i, prescaler_ratio_select_i} <= '0;
    {cfg_wdt_period_sel_i, watchdog_run_enable_i, prescaler_to_watchdog_select_i} <= '0;
    {external_irq_select_i, external_edge_select_i} <= '0;
    {rst_i, cfg_wdt_enable_i, cfg_wdt_irq_mode_i} <= 3'b111;
    {timer0_count_i, timer1_count_i} <= 16'h1010;
    {portb_dir_input_i, portb_pin_change_enable_i} <= 16'hffff;
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk({interrupt_flag_reg_o, global_irq_enable_o}, {FLAG_RST, GIE_RST});
    strobe(9'h010, 8'h00);
    chk({vector_load_o, vector_addr_o}, {1'b1, VEC_TRAP});
    chk({global_irq_enable_o, isr_active_o}, 2'b01);
    strobe(9'h008, 8'h00);
    chk({global_irq_enable_o, isr_active_o}, 2'b10);
    strobe(9'h004, 8'h00);
    chk(global_irq_enable_o, 1'b0);
    strobe(9'h002, 8'h00);
    chk(global_irq_enable_o, 1'b1);
    $display("test trap done");
    strobe(9'h100, 8'h4f);
    chk(interrupt_enable_reg_o, 8'h4f);
    @(posedge ref_clk_i);
    timer0_count_i <= CNT_TOP;
    @(posedge ref_clk_i);
    timer0_count_i <= CNT_BOT;
    wait_hi(8, 6, n);
    chk({vector_load_o, vector_addr_o, global_irq_enable_o}, {1'b1, VEC_HW, 1'b0});
    chk(interrupt_flag_reg_o, 8'h01);
    strobe(9'h001, 8'hfe);
    chk(interrupt_flag_reg_o, 8'h00);
    strobe(9'h100, 8'h47);
    @(posedge ref_clk_i);
    timer1_count_i <= CNT_TOP;
    @(posedge ref_clk_i);
    timer1_count_i <= CNT_BOT;
    // Clearing write in the cycle the underflow is seen
    strb <= 9'h001;
    flag_wdata_i <= 8'h00;
    @(posedge ref_clk_i);
    strb <= 9'h000;
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk(interrupt_flag_reg_o, 8'h00);
    strobe(9'h100, 8'h4f);
    chk(interrupt_flag_reg_o, 8'h08);
    strobe(9'h002, 8'h00);
    wait_hi(8, 4, n);
    chk({vector_load_o, vector_addr_o}, {1'b1, VEC_HW});
    strobe(9'h001, 8'h00);
    $display("test timers done");
    @(posedge ref_clk_i);
    portb_pin_i <= 8'h08;
    wait_hi(1, 6, n);
    chk(interrupt_flag_reg_o, 8'h02);
    @(posedge ref_clk_i);
    external_irq_select_i <= 1'b1;
    external_edge_select_i <= 1'b1;
    strobe(9'h001, 8'h00);
    @(posedge ref_clk_i);
    portb_pin_i <= 8'h09;
    repeat (6) @(posedge ref_clk_i);
    #1;
    chk(interrupt_flag_reg_o, 8'h04);
    $display("test port done");
    strobe(9'h001, 8'h00);
    repeat (60) @(posedge ref_clk_i);
    #1;
    chk(interrupt_flag_reg_o, 8'h00);
    @(posedge ref_clk_i);
    watchdog_run_enable_i <= 1'b1;
    wait_hi(6, 200, n);
    chk(n >= 16 && n <= 40, 1'b1);
    @(posedge ref_clk_i);
    #1;
    chk({interrupt_flag_reg_o, timeout_status_flag_o}, 9'h080);
    @(posedge ref_clk_i);
    prescaler_to_watchdog_select_i <= 1'b1;
    prescaler_ratio_select_i <= 3'h1;
    strobe(9'h021, 8'h00);
    chk(timeout_status_flag_o, 1'b1);
    wait_hi(6, 300, n);
    chk(n >= 88 && n <= 112, 1'b1);
    strobe(9'h040, 8'h00);
    chk({power_down_flag_o, timeout_status_flag_o}, 2'b01);
    @(posedge ref_clk_i);
    #1;
    chk(wake_o, 1'b1);
    strobe(9'h080, 8'h00);
    @(posedge ref_clk_i);
    #1;
    chk(wake_o, 1'b1);
    @(posedge ref_clk_i);
    cfg_wdt_irq_mode_i <= 1'b0;
    prescaler_to_watchdog_select_i <= 1'b0;
    strobe(9'h021, 8'h00);
    wait_hi(9, 100, n);
    chk({watchdog_reset_o, interrupt_flag_reg_o[6]}, 2'b10);
    $display("test watchdog done");
    chk(pc, VEC_HW);
    chk(fetches, 8'h03);
    complete_run();
  end
endmodule
`default_nettype wire
